/* adcsr_map.svh */
`ifndef ADCSR_MAP_SVH
`define ADCSR_MAP_SVH
// Result word width and busy bit framing
`define ADCSR_WORD_BITS 16
`define ADCSR_CS_BUSY_EDGES 17
`define ADCSR_DC_WORD_EDGES 16
// Conversion timing, internal oscillator at 10 MHz (100 ns)
`define ADCSR_CLK_PERIOD_NS 100
`define ADCSR_CONV_TIME_NS 1000
`define ADCSR_CONV_CYCLES ((`ADCSR_CONV_TIME_NS + `ADCSR_CLK_PERIOD_NS - 1) / `ADCSR_CLK_PERIOD_NS)
// Reset value of the result register
`define ADCSR_RESULT_RST 16'h0000
// Output line levels
`define ADCSR_BUSY_LEVEL 1'b0
`endif

/* adcsr_pkg.sv */
package adcsr_pkg;
  typedef enum logic [2:0] {
    ADCSR_IDLE,
    ADCSR_CONV,
    ADCSR_CS_READ,
    ADCSR_DC_READ,
    ADCSR_DONE
  } adcsr_state_t;
  typedef enum logic [1:0] {
    ADCSR_MODE_CS,
    ADCSR_MODE_DC,
    ADCSR_MODE_DC_BUSY
  } adcsr_mode_t;
endpackage

/* adcsr_fifo.sv */
`timescale 1ns/10ps
// ****************************************
// Small flip-flop FIFO for result words
// ****************************************
module adcsr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;

  // Handshakes on both sides
  assign do_wr = wr_valid_in && (count_reg != (AW+1)'(DEPTH));
  assign do_rd = rd_ready_in && (count_reg != '0);
  assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_reg != '0);
  assign rd_data_out = mem_reg[rd_ptr_reg];

  // Storage, no reset needed on data
  always_ff @(posedge ref_clk_in) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (!do_wr && do_rd) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

/* adcsr_core.sv */
// Notes on behaviour
// RULE1: Input line high at strobe rise selects chip-select mode.
// RULE2: Input line low at strobe rise selects daisy-chain mode.
// RULE3: Chip-select strobe rise floats output, samples input, starts converting.
// RULE4: Host keeps strobe high until all chip-select data is read.
// RULE5: Host drives input line low through conversion to request busy.
// RULE6: Busy only if input line low at conversion end; conversion always runs.
// RULE7: At end with busy: power down, enable output, drive low busy bit.
// RULE8: After busy bit, MSB on first shift fall, then lower bits.
// RULE9: Chip-select busy: float after 17th fall or input line high.
// RULE10: Host never holds strobe and input line low together in chip-select.
// RULE11: Output driven low whenever input line and strobe are both low.
// RULE12: Host holds shift clock low at strobe rise for chain without busy.
// RULE13: Host holds shift clock high at strobe rise for chain with busy.
// RULE14: Host keeps strobe high in chain mode; conversion ignores shift clock.
// RULE15: Chain without busy: MSB at conversion end, lower bits on falls.
// RULE16: Chain captures input on each fall; emits upstream data after own word.
// RULE17: Chain without busy: grounded first device outputs low after 16th fall.
// RULE18: Host gives sixteen shift clocks per device without busy.
// RULE19: Chain with busy: first device enters chain mode with both rising.
// RULE20: Chain with busy: busy bit at end, MSB on first following fall.
// RULE21: Chain with busy: first device outputs high after 17th fall.
// RULE22: Host gives sixteen pulses per device plus one with busy.
// RULE23: Busy indicator is one bit sent before the sixteen-bit word.
// RULE24: Result word is two's complement coded, 7fff to 8000.
// RULE25: Conversion lasts a fixed parameter count of internal clock cycles.
`timescale 1ns/10ps
`include "adcsr_map.svh"
module adcsr_core
  import adcsr_pkg::*;
#(
  parameter int WORD_BITS = `ADCSR_WORD_BITS,
  parameter int CONV_CYCLES = `ADCSR_CONV_CYCLES,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic conversion_start_strobe_in,
  input wire logic serial_input_line_in,
  input wire logic shift_clk_in,
  input wire logic [WORD_BITS-1:0] sample_code_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  output logic serial_output_line_out,
  output logic serial_output_line_oe_out,
  output logic converter_powered_out,
  output logic [1:0] mode_out
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] strobe_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic strobe_q_reg;
  logic sdi_q_reg;
  logic sclk_q_reg;
  logic strobe_s;
  logic sdi_s;
  logic sclk_s;
  logic strobe_rise;
  logic sclk_fall;

  // Two sync flops per pin plus a delay flop; logic reads the second stage and the delay flop
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      strobe_sync_reg <= 2'h0;
      sdi_sync_reg <= 2'h0;
      sclk_sync_reg <= 2'h0;
      strobe_q_reg <= 1'b0;
      sdi_q_reg <= 1'b0;
      sclk_q_reg <= 1'b0;
    end else begin
      strobe_sync_reg <= {strobe_sync_reg[0], conversion_start_strobe_in};
      sdi_sync_reg <= {sdi_sync_reg[0], serial_input_line_in};
      sclk_sync_reg <= {sclk_sync_reg[0], shift_clk_in};
      strobe_q_reg <= strobe_sync_reg[1];
      sdi_q_reg <= sdi_sync_reg[1];
      sclk_q_reg <= sclk_sync_reg[1];
    end
  end

  assign strobe_s = strobe_sync_reg[1];
  assign sdi_s = sdi_sync_reg[1];
  assign sclk_s = sclk_sync_reg[1];
  assign strobe_rise = strobe_s && !strobe_q_reg;
  assign sclk_fall = !sclk_s && sclk_q_reg;

  // ****************************************
  // Result buffer between converter and shifter
  // ****************************************
  logic [WORD_BITS-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  adcsr_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_data_in(sample_code_in),
    .wr_valid_in(sample_valid_in),
    .wr_ready_out(sample_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop)
  );

  // ****************************************
  // Mode capture and conversion control
  // ****************************************
  adcsr_state_t state_reg;
  adcsr_mode_t mode_reg;
  logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt_reg;
  logic [WORD_BITS-1:0] result_reg;
  logic [WORD_BITS-1:0] chain_reg;
  logic [5:0] edge_cnt_reg;
  logic busy_req_reg;
  logic conv_done;

  assign conv_done = (state_reg == ADCSR_CONV) && (conv_cnt_reg == '0);
  // Sampled code is already two's complement; the converter front end owns scaling
  assign fifo_pop = conv_done; // RULE24

  // Conversion state; strobe rise restarts from any state
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ADCSR_IDLE;
      conv_cnt_reg <= '0;
    end else if (strobe_rise) begin
      state_reg <= ADCSR_CONV; // RULE3
      conv_cnt_reg <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1); // RULE25
    end else begin
      unique case (state_reg)
        ADCSR_IDLE: begin
          state_reg <= ADCSR_IDLE;
        end
        ADCSR_CONV: begin
          // Shift clock is ignored here on purpose
          if (conv_cnt_reg != '0) begin
            conv_cnt_reg <= conv_cnt_reg - 1'b1; // RULE14
          end else if (mode_reg == ADCSR_MODE_CS) begin
            state_reg <= busy_req_reg ? ADCSR_CS_READ : ADCSR_DONE; // RULE6
          end else begin
            state_reg <= ADCSR_DC_READ;
          end
        end
        ADCSR_CS_READ: begin
          // Early end when the host raises its select
          if (sdi_s || (sclk_fall && edge_cnt_reg == 6'(`ADCSR_CS_BUSY_EDGES - 1))) begin
            state_reg <= ADCSR_DONE; // RULE9
          end
        end
        ADCSR_DC_READ: begin
          state_reg <= strobe_s ? ADCSR_DC_READ : ADCSR_IDLE;
        end
        ADCSR_DONE: begin
          state_reg <= strobe_s ? ADCSR_DONE : ADCSR_IDLE;
        end
      endcase
    end
  end

  // Mode select taken at the strobe rise
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mode_reg <= ADCSR_MODE_CS;
    end else if (strobe_rise) begin
      // Input line as it stood one clock before the rise, so a line tied to
      // the strobe still reads low and selects the chain
      if (sdi_q_reg) begin
        mode_reg <= ADCSR_MODE_CS; // RULE1
      end else if (sclk_s) begin
        mode_reg <= ADCSR_MODE_DC_BUSY; // RULE2 RULE13 RULE19
      end else begin
        mode_reg <= ADCSR_MODE_DC; // RULE12
      end
    end
  end

  // Busy request tracks the select line; the last value before the end counts
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      busy_req_reg <= 1'b0;
    end else if (state_reg == ADCSR_CONV) begin
      busy_req_reg <= !sdi_s; // RULE5 RULE6
    end
  end

  // ****************************************
  // Output shift registers
  // ****************************************
  // Own word and upstream capture run in parallel
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      result_reg <= `ADCSR_RESULT_RST;
      chain_reg <= `ADCSR_RESULT_RST;
      edge_cnt_reg <= 6'h00;
    end else if (conv_done) begin
      result_reg <= fifo_valid ? fifo_data : `ADCSR_RESULT_RST;
      chain_reg <= `ADCSR_RESULT_RST;
      edge_cnt_reg <= 6'h00;
    end else if (sclk_fall && (state_reg == ADCSR_CS_READ || state_reg == ADCSR_DC_READ)) begin
      if (edge_cnt_reg != 6'h3f) begin
        edge_cnt_reg <= edge_cnt_reg + 6'h01;
      end
      if (state_reg == ADCSR_DC_READ) begin
        chain_reg <= {chain_reg[WORD_BITS-2:0], sdi_s}; // RULE16
      end
      // Busy framing holds the word for the first fall
      if (!(edge_cnt_reg == 6'h00 && mode_reg != ADCSR_MODE_DC)) begin
        result_reg <= {result_reg[WORD_BITS-2:0], 1'b0}; // RULE8 RULE15
      end
    end
  end

  // ****************************************
  // Serial output pin
  // ****************************************
  logic dc_own_phase;
  logic [5:0] own_edges;

  assign own_edges = (mode_reg == ADCSR_MODE_DC_BUSY) ? 6'(`ADCSR_CS_BUSY_EDGES)
                                                      : 6'(`ADCSR_DC_WORD_EDGES);
  assign dc_own_phase = edge_cnt_reg < own_edges;

  // Output level and enable, both registered
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      serial_output_line_out <= 1'b0;
      serial_output_line_oe_out <= 1'b0;
    end else if (!strobe_s && !sdi_s) begin
      serial_output_line_out <= 1'b0; // RULE11
      serial_output_line_oe_out <= 1'b1;
    end else if (state_reg == ADCSR_CS_READ) begin
      serial_output_line_oe_out <= 1'b1; // RULE7
      serial_output_line_out <= (edge_cnt_reg == 6'h00) ? `ADCSR_BUSY_LEVEL
                                                        : result_reg[WORD_BITS-1]; // RULE23
    end else if (state_reg == ADCSR_DC_READ) begin
      serial_output_line_oe_out <= 1'b1;
      if (mode_reg == ADCSR_MODE_DC_BUSY && edge_cnt_reg == 6'h00) begin
        serial_output_line_out <= `ADCSR_BUSY_LEVEL; // RULE20
      end else if (dc_own_phase) begin
        serial_output_line_out <= result_reg[WORD_BITS-1];
      end else begin
        // Grounded input gives low, input tied to strobe gives high
        serial_output_line_out <= chain_reg[WORD_BITS-1]; // RULE16 RULE17 RULE21
      end
    end else begin
      serial_output_line_out <= 1'b0;
      serial_output_line_oe_out <= 1'b0; // RULE3 RULE9
    end
  end

  // Converter powers up only while converting
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      converter_powered_out <= 1'b0;
      mode_out <= 2'h0;
    end else begin
      converter_powered_out <= (state_reg == ADCSR_CONV); // RULE7 RULE25
      mode_out <= mode_reg;
    end
  end
endmodule

/* adcsr_core_asserts.sv */
`timescale 1ns/10ps
// ****************************************
// Port checker for the readout chain
// ****************************************
module adcsr_core_asserts #(
  parameter int WORD_BITS = 16,
  parameter int CONV_CYCLES = 10,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic conversion_start_strobe_in,
  input wire logic serial_input_line_in,
  input wire logic shift_clk_in,
  input wire logic [WORD_BITS-1:0] sample_code_in,
  input wire logic sample_valid_in,
  input wire logic sample_ready_out,
  input wire logic serial_output_line_out,
  input wire logic serial_output_line_oe_out,
  input wire logic converter_powered_out,
  input wire logic [1:0] mode_out
);
  logic st, si, so, oe, pw;
  logic [7:0] pw_cnt_reg;
  // Short aliases keep the properties readable
  assign st = conversion_start_strobe_in;
  assign si = serial_input_line_in;
  assign so = serial_output_line_out;
  assign oe = serial_output_line_oe_out;
  assign pw = converter_powered_out;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Powered cycles so far, so the conversion length is pinned exactly
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !pw) begin
      pw_cnt_reg <= 8'h00;
    end else begin
      pw_cnt_reg <= pw_cnt_reg + 8'h01;
    end
  end
  property p_mode_cs;
    $rose(st) && si && $past(si) |-> ##5 mode_out == 2'h0;
  endproperty
  a_mode_cs: assert property (p_mode_cs) else $error("cs mode missed");
  property p_mode_dc;
    $rose(st) && !si && !shift_clk_in |-> ##5 mode_out == 2'h1;
  endproperty
  a_mode_dc: assert property (p_mode_dc) else $error("chain mode missed");
  property p_start;
    $rose(st) && si && $past(si) |-> ##5 !oe && pw;
  endproperty
  a_start: assert property (p_start) else $error("no float or no conversion");
  property p_conv_len;
    $fell(pw) |-> pw_cnt_reg == CONV_CYCLES;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length off");
  property p_busy;
    $fell(pw) && (mode_out == 2'h2 || (mode_out == 2'h0 && !si)) |-> ##[0:1] (oe && !so);
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit missing");
  property p_no_busy;
    $fell(pw) && mode_out == 2'h0 && si |-> ##1 !oe;
  endproperty
  a_no_busy: assert property (p_no_busy) else $error("unrequested busy");
  property p_force_low;
    (!st && !si)[*4] |-> oe && !so;
  endproperty
  a_force_low: assert property (p_force_low) else $error("output not low");
  property p_release;
    mode_out == 2'h0 && st && $rose(si) |-> ##5 !oe;
  endproperty
  a_release: assert property (p_release) else $error("output not released");
  c_cs: cover property (mode_out == 2'h0 && oe && !so);
  c_dc: cover property (mode_out == 2'h1 && oe);
  c_dcb: cover property (mode_out == 2'h2 && oe);
endmodule
bind adcsr_core adcsr_core_asserts #(.WORD_BITS(WORD_BITS), .CONV_CYCLES(CONV_CYCLES),
  .FIFO_DEPTH(FIFO_DEPTH)) chk (.ref_clk_in, .sys_rst_in, .conversion_start_strobe_in,
  .serial_input_line_in, .shift_clk_in, .sample_code_in, .sample_valid_in, .sample_ready_out,
  .serial_output_line_out, .serial_output_line_oe_out, .converter_powered_out, .mode_out);

/* adcsr_host.sv */
`timescale 1ns/10ps
// ****************************************
// Host model: strobe, input line, shift clock
// ****************************************
module adcsr_host (
  input wire logic ref_clk_in,
  input wire logic line_in,
  input wire logic line_oe_in,
  output logic strobe_out,
  output logic sin_out,
  output logic sclk_out
);
  initial begin
    strobe_out = 1'b0;
    sin_out = 1'b1;
    sclk_out = 1'b0;
  end
  // Set pins just after an edge and hold them n clocks
  task automatic drive(input logic s, input logic d, input logic c, input int n);
    strobe_out <= s;
    sin_out <= d;
    sclk_out <= c;
    repeat (n) @(posedge ref_clk_in);
  endtask
  // Falls 8 clocks apart; a floated line reads as the inverse of the last bit
  // With tie set the input line follows the strobe, as on a first busy-chain device
  task automatic read(input int n, input logic [15:0] up, input logic tie,
                      output logic [32:0] bits);
    logic last;
    last = 1'b0;
    bits = '0;
    for (int k = 0; k < n; k++) begin
      sclk_out <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      sin_out <= tie ? strobe_out : (k < 16) ? up[15-k] : 1'b0;
      repeat (2) @(posedge ref_clk_in);
      last = line_oe_in ? line_in : ~last;
      bits = {bits[31:0], last};
      sclk_out <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
    end
  endtask
endmodule

/* tb.sv */
`timescale 1ns/10ps
// ****************************************
// Self-checking bench for the readout chain
// ****************************************
module tb;
  logic clk, rst, strobe, sin, sclk, valid, ready, out, oe, pwr;
  logic [15:0] code;
  logic [1:0] mode;
  logic [31:0] lfsr;
  logic [15:0] q[$];
  int n_fail, total_checks;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  adcsr_core uut (.ref_clk_in(clk), .sys_rst_in(rst), .conversion_start_strobe_in(strobe),
    .serial_input_line_in(sin), .shift_clk_in(sclk), .sample_code_in(code),
    .sample_valid_in(valid), .sample_ready_out(ready), .serial_output_line_out(out),
    .serial_output_line_oe_out(oe), .converter_powered_out(pwr), .mode_out(mode));
  adcsr_host host (.ref_clk_in(clk), .line_in(out), .line_oe_in(oe), .strobe_out(strobe),
    .sin_out(sin), .sclk_out(sclk));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Busy bit (if any), own word, then upstream word, as sampled
  function automatic logic [32:0] expect_bits(input int m, input logic [15:0] w,
                                              input logic [15:0] u, input int n);
    logic [32:0] s;
    s = (m == 1) ? {w, u, 1'b0} : {1'b0, w, u};
    return s >> (33 - n);
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Bounded wait for the conversion to end
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40 && (i < 6 || pwr !== 1'b0); i++) @(posedge clk);
    if (i == 40) begin
      n_fail++;
      final_report();
    end
  endtask
  // Push corner then random codes until the buffer refuses
  task automatic fill();
    logic [15:0] w;
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      w = (i == 0) ? 16'h7fff : (i == 1) ? 16'h8000 : lfsr[15:0];
      code <= w;
      valid <= 1'b1;
      @(posedge clk);
      if (ready === 1'b1) q.push_back(w);
    end
    valid <= 1'b0;
    check(33'(q.size()), 33'h4);
    check(ready, 1'b0);
  endtask
  // Modes: 0 cs with busy, 1 chain, 2 chain with busy; cut stops early
  task automatic convert(input int m, input logic [15:0] up, input int cut);
    logic [32:0] bits;
    logic [15:0] w;
    int n;
    w = (q.size() > 0) ? q.pop_front() : 16'h0000;
    n = (cut > 0) ? cut : (m == 0) ? 17 : 31 + m;
    host.drive(1'b0, m == 0, 1'b0, 5);
    if (m > 0) check({oe, out}, 2'b10);
    host.drive(1'b0, m == 0, m == 2, 3);
    host.drive(1'b1, m != 1, m == 2, 3);
    host.drive(1'b1, m == 2, m == 2, 1);
    wait_idle();
    check(mode, m[1:0]);
    host.read(n, up, m == 2, bits);
    check(bits, expect_bits(m, w, up, n));
    repeat (2) @(posedge clk);
    if (m == 0 && cut == 0) check(oe, 1'b0);
    host.drive(1'b1, 1'b1, 1'b0, 6);
    if (m == 0) check(oe, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    valid = 1'b0;
    code = 16'h0000;
    lfsr = 32'h33896fd9;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int r = 0; r < 2; r++) begin
      fill();
      convert(0, 16'h0000, 0);
      convert(1, 16'h0000, 0);
      convert(2, 16'hffff, 0);
      lfsr = next_rand(lfsr);
      convert(1, lfsr[31:16], 0);
      convert(0, 16'h0000, 9);
      // Input line kept high: no busy requested, output must stay floated
      host.drive(1'b0, 1'b1, 1'b0, 5);
      host.drive(1'b1, 1'b1, 1'b0, 1);
      wait_idle();
      repeat (3) @(posedge clk);
      check(oe, 1'b0);
      $display("round %0d done", r);
    end
    final_report();
  end
endmodule
